/* File: design/npic_pkg.sv */
// shared constants, types and helper functions of the nested interrupt controller
package npic_pkg;
    localparam int NUM_VEC = 14;
    localparam int NUM_VPR = 4;
    localparam int CTX_BYTES = 5;
    localparam logic [2:0] CTX_LAST = 3'h4;
    // current / stored priority encodings {high, low}
    localparam logic [1:0] PRIO_L0 = 2'h2;
    localparam logic [1:0] PRIO_L1 = 2'h1;
    localparam logic [1:0] PRIO_L2 = 2'h0;
    localparam logic [1:0] PRIO_L3 = 2'h3;
    localparam int CC_BIT_HIGH = 5;
    localparam int CC_BIT_LOW = 3;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_BASE = 16'hfffa;
    localparam logic [7:0] VPR_RESET = 8'hff;
    localparam logic [7:0] VPR3_RO_MASK = 8'hf0;
    // vectors that may end halt, and the two external pin groups
    localparam logic [NUM_VEC-1:0] HALT_WAKE_MASK = 14'h000e;
    localparam int EXT_VEC_A = 2;
    localparam int EXT_VEC_B = 3;
    localparam int NUM_EXT_GRP = 2;
    localparam int EXT_PINS_PER_GRP = 2;
    // sense field layout inside the external sensitivity register
    localparam int SENSE_POS_A = 4;
    localparam int SENSE_POS_B = 6;
    localparam int EXT_EN_POS = 0;
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] x;
        logic [7:0] a;
        logic [7:0] cc;
    } npic_ctx_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PUSH = 5'h02,
        ST_VEC = 5'h04,
        ST_POP = 5'h08,
        ST_RESTORE = 5'h10
    } npic_state_e;

    // numeric nesting level of a two-bit priority code
    function automatic logic [1:0] prio_level(input logic [1:0] code);
        case (code)
            PRIO_L0: prio_level = 2'h0;
            PRIO_L1: prio_level = 2'h1;
            PRIO_L2: prio_level = 2'h2;
            default: prio_level = 2'h3;
        endcase
    endfunction

    function automatic logic [15:0] vec_addr(input logic [3:0] idx);
        vec_addr = VEC_BASE - {11'h000, idx, 1'b0};
    endfunction

    // stack order: low pc byte first, condition code last
    function automatic logic [7:0] ctx_byte(input npic_ctx_s ctx, input logic [2:0] i);
        case (i)
            3'h0: ctx_byte = ctx.pc[7:0];
            3'h1: ctx_byte = ctx.pc[15:8];
            3'h2: ctx_byte = ctx.x;
            3'h3: ctx_byte = ctx.a;
            default: ctx_byte = ctx.cc;
        endcase
    endfunction
endpackage

/* File: design/npic_ctrl.sv */
// nested priority interrupt controller: arbitration, context stacking, vector load
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - two cc bits encode current level
// - enter at end of instruction, or in halt, in wait or for reset
// - push pc, x, a, cc on entry
// - maskable entry loads its stored priority
// - then load vector, start handler fetch
// - sixteen fixed vectors, four nesting levels
// - return restores context and priority bits
// - highest software level, then hardware order
// - unserviced requests stay latched until highest
// - reset, trap, top irq bypass mask, rank first
// - non-maskable: stack except reset, level 3
// - reset and top irq end halt; trap is ignored in halt
// - top irq on pin edge, preempts trap
// - reset highest, its routine at level 3
// - maskable needs enable and higher stored level
// - external pins wake halt, sense selectable
// - edge requests latch, clear on entry
// - shared line NANDs its selected pins
// - peripheral request needs flag and enable
// - clearing sequence drops the pending latch
// - any irq ends wait; halt exit takes wakers
// - four registers hold per-vector priority
// - level 0 writes to a field ignored
module npic_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_end,
    input wire logic trap_exec,
    input wire logic return_from_irq,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cc_sw_wr,
    input wire logic [1:0] cc_sw_prio,
    input wire npic_pkg::npic_ctx_s core_ctx,
    input wire logic top_level_irq,
    input wire logic tli_rising,
    input wire logic [3:0] ext_pin,
    input wire logic [7:0] ext_irq_sense_reg,
    input wire logic [13:0] periph_flag,
    input wire logic [13:0] periph_en,
    input wire logic [13:0] periph_clear,
    input wire logic vpr_wr,
    input wire logic [1:0] vpr_wr_idx,
    input wire logic [7:0] vpr_wdata,
    input wire logic [7:0] stack_rdata,
    output logic core_hold,
    output logic stack_wr,
    output logic [7:0] stack_wdata,
    output logic stack_rd,
    output logic pc_load,
    output logic [15:0] program_counter,
    output logic [3:0] serviced_idx,
    output logic restore_valid,
    output npic_pkg::npic_ctx_s restore_ctx,
    output logic halt_exit,
    output logic wait_exit,
    output logic prio_bit_high,
    output logic prio_bit_low,
    output logic [31:0] vector_priority_regs
);
    npic_pkg::npic_state_e state_reg;
    logic [2:0] cnt_reg;
    logic [1:0] cur_prio_reg;
    logic [7:0] vpr_reg [npic_pkg::NUM_VPR];
    logic sample_ok_reg;
    logic tli_prev_reg;
    logic tli_pend_reg;
    logic trap_pend_reg;
    logic reset_pend_reg;
    logic [1:0] grp_prev_reg;
    logic [1:0] ext_latch_reg;
    logic [13:0] periph_pend_reg;
    npic_pkg::npic_ctx_s ctx_reg;
    npic_pkg::npic_ctx_s rest_reg;
    logic [7:0] wdata_reg;
    logic [15:0] ent_vec_reg;
    logic [1:0] ent_prio_reg;
    logic [3:0] ent_idx_reg;
    logic ent_mask_reg;
    logic [1:0] grp_line;
    logic [1:0] grp_nand;
    logic [1:0] grp_edge;
    logic [1:0] grp_level;
    logic [13:0] req_vec;
    logic [13:0] cand_vec;
    logic found;
    logic [3:0] best_idx;
    logic [1:0] best_lvl;
    logic trap_eff;
    logic tli_edge;
    logic any_cand;
    logic take;
    logic sel_reset;
    logic sel_trap;
    logic sel_tli;

    assign vector_priority_regs = {vpr_reg[3], vpr_reg[2], vpr_reg[1], vpr_reg[0]};
    assign prio_bit_high = cur_prio_reg[1];
    assign prio_bit_low = cur_prio_reg[0];

    // stored priority of a vector, same code as the cc bits
    function automatic logic [1:0] vec_prio(input logic [31:0] flat, input int v);
        vec_prio = flat[2*v +: 2];
    endfunction

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < npic_pkg::NUM_VPR; i++)
            begin
                vpr_reg[i] <= npic_pkg::VPR_RESET;
            end
        end
        else if (vpr_wr)
        begin
            for (int f = 0; f < 4; f++)
            begin
                if (vpr_wdata[2*f +: 2] != npic_pkg::PRIO_L0)
                begin
                    vpr_reg[vpr_wr_idx][2*f +: 2] <= vpr_wdata[2*f +: 2];
                end
            end
            if (vpr_wr_idx == 2'h3)
            begin
                vpr_reg[3][7:4] <= npic_pkg::VPR3_RO_MASK[7:4];
            end
        end
    end

    // pin samples are only trusted once a first clock has passed since reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_ok_reg <= 1'b0;
            tli_prev_reg <= 1'b0;
            grp_prev_reg <= 2'h0;
        end
        else
        begin
            sample_ok_reg <= 1'b1;
            tli_prev_reg <= top_level_irq;
            grp_prev_reg <= grp_line;
        end
    end

    assign tli_edge = sample_ok_reg
        & (tli_rising ? (top_level_irq & ~tli_prev_reg) : (~top_level_irq & tli_prev_reg));

    generate
        for (genvar g = 0; g < npic_pkg::NUM_EXT_GRP; g++)
        begin : g_ext
            localparam int SPOS = (g == 0) ? npic_pkg::SENSE_POS_A : npic_pkg::SENSE_POS_B;
            localparam int PB = g * npic_pkg::EXT_PINS_PER_GRP;
            logic [1:0] en;
            logic [1:0] sense;
            logic any_en;
            logic rise;
            logic fall;
            assign en = ext_irq_sense_reg[npic_pkg::EXT_EN_POS + PB +: 2];
            assign sense = ext_irq_sense_reg[SPOS +: 2];
            assign any_en = |en;
            // unselected pins read as high so they never mask the others
            assign grp_line[g] = &(ext_pin[PB +: 2] | ~en);
            assign grp_nand[g] = ~grp_line[g];
            assign rise = sample_ok_reg & grp_line[g] & ~grp_prev_reg[g];
            assign fall = sample_ok_reg & ~grp_line[g] & grp_prev_reg[g];
            always_comb
            begin
                case (sense)
                    npic_pkg::SENSE_RISE: grp_edge[g] = any_en & rise;
                    npic_pkg::SENSE_BOTH: grp_edge[g] = any_en & (rise | fall);
                    default: grp_edge[g] = any_en & fall;
                endcase
            end
            assign grp_level[g] = any_en & grp_nand[g] & (sense == npic_pkg::SENSE_FALL_LOW);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_latch_reg <= 2'h0;
        end
        else
        begin
            for (int g = 0; g < npic_pkg::NUM_EXT_GRP; g++)
            begin
                if (grp_edge[g])
                begin
                    ext_latch_reg[g] <= 1'b1;
                end
                else if (take && !sel_reset && !sel_trap && !sel_tli
                    && best_idx == 4'(npic_pkg::EXT_VEC_A + g))
                begin
                    ext_latch_reg[g] <= 1'b0;
                end
            end
        end
    end

    // peripheral latch: the clearing sequence wins over a same-cycle request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            periph_pend_reg <= 14'h0000;
        end
        else
        begin
            periph_pend_reg <= (periph_pend_reg | (periph_flag & periph_en))
                & ~periph_clear;
        end
    end

    generate
        for (genvar v = 0; v < npic_pkg::NUM_VEC; v++)
        begin : g_req
            if (v == 0)
            begin : g_tli_slot
                assign req_vec[v] = 1'b0;
            end
            else if (v == npic_pkg::EXT_VEC_A || v == npic_pkg::EXT_VEC_B)
            begin : g_ext_slot
                localparam int G = v - npic_pkg::EXT_VEC_A;
                assign req_vec[v] = ext_latch_reg[G] | grp_level[G];
            end
            else
            begin : g_per_slot
                assign req_vec[v] = periph_pend_reg[v];
            end
        end
    endgenerate

    // in halt only wake-capable vectors may be chosen first
    assign cand_vec = halt_mode ? (req_vec & npic_pkg::HALT_WAKE_MASK) : req_vec;

    // walk from lowest hardware priority up; ties go to the later, higher one
    always_comb
    begin
        found = 1'b0;
        best_idx = 4'h0;
        best_lvl = 2'h0;
        for (int v = npic_pkg::NUM_VEC - 1; v >= 1; v--)
        begin
            if (cand_vec[v]
                && npic_pkg::prio_level(vec_prio(vector_priority_regs, v))
                    > npic_pkg::prio_level(cur_prio_reg)
                && (!found
                    || npic_pkg::prio_level(vec_prio(vector_priority_regs, v)) >= best_lvl))
            begin
                found = 1'b1;
                best_idx = 4'(v);
                best_lvl = npic_pkg::prio_level(vec_prio(vector_priority_regs, v));
            end
        end
    end

    assign trap_eff = (trap_pend_reg | trap_exec) & ~halt_mode;
    assign sel_reset = reset_pend_reg;
    assign sel_trap = ~sel_reset & trap_eff;
    assign sel_tli = ~sel_reset & ~trap_eff & tli_pend_reg;
    assign any_cand = reset_pend_reg | trap_eff | tli_pend_reg | found;
    assign take = (state_reg == npic_pkg::ST_IDLE) && !return_from_irq
        && (instr_end || halt_mode || wait_mode || reset_pend_reg) && any_cand;

    assign halt_exit = take & halt_mode;
    assign wait_exit = take & wait_mode;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reset_pend_reg <= 1'b1;
            trap_pend_reg <= 1'b0;
            tli_pend_reg <= 1'b0;
        end
        else
        begin
            if (take && sel_reset)
            begin
                reset_pend_reg <= 1'b0;
            end
            if (take && sel_trap)
            begin
                trap_pend_reg <= 1'b0;
            end
            else if (trap_exec)
            begin
                trap_pend_reg <= 1'b1;
            end
            // a new edge beats the clear of an older one
            if (tli_edge)
            begin
                tli_pend_reg <= 1'b1;
            end
            else if (take && sel_tli)
            begin
                tli_pend_reg <= 1'b0;
            end
        end
    end

    // a running trap handler sits at level 3, yet the top irq still enters
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ent_vec_reg <= npic_pkg::VEC_RESET;
            ent_prio_reg <= npic_pkg::PRIO_L3;
            ent_idx_reg <= 4'h0;
            ent_mask_reg <= 1'b0;
            ctx_reg <= '0;
        end
        else if (take)
        begin
            ctx_reg <= core_ctx;
            ent_mask_reg <= ~(sel_reset | sel_trap | sel_tli);
            if (sel_reset)
            begin
                ent_vec_reg <= npic_pkg::VEC_RESET;
                ent_prio_reg <= npic_pkg::PRIO_L3;
                ent_idx_reg <= 4'h0;
            end
            else if (sel_trap)
            begin
                ent_vec_reg <= npic_pkg::VEC_TRAP;
                ent_prio_reg <= npic_pkg::PRIO_L3;
                ent_idx_reg <= 4'h0;
            end
            else if (sel_tli)
            begin
                ent_vec_reg <= npic_pkg::vec_addr(4'h0);
                ent_prio_reg <= npic_pkg::PRIO_L3;
                ent_idx_reg <= 4'h0;
            end
            else
            begin
                ent_vec_reg <= npic_pkg::vec_addr(best_idx);
                ent_prio_reg <= vec_prio(vector_priority_regs, int'(best_idx));
                ent_idx_reg <= best_idx;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= npic_pkg::ST_IDLE;
            cnt_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                npic_pkg::ST_IDLE:
                begin
                    cnt_reg <= 3'h0;
                    if (return_from_irq)
                    begin
                        state_reg <= npic_pkg::ST_POP;
                    end
                    else if (take)
                    begin
                        // reset starts fresh, nothing worth saving
                        state_reg <= sel_reset ? npic_pkg::ST_VEC : npic_pkg::ST_PUSH;
                    end
                end
                npic_pkg::ST_PUSH:
                begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == npic_pkg::CTX_LAST)
                    begin
                        state_reg <= npic_pkg::ST_VEC;
                    end
                end
                npic_pkg::ST_VEC:
                begin
                    state_reg <= npic_pkg::ST_IDLE;
                end
                npic_pkg::ST_POP:
                begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == npic_pkg::CTX_LAST)
                    begin
                        state_reg <= npic_pkg::ST_RESTORE;
                    end
                end
                default:
                begin
                    state_reg <= npic_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // write data comes from a flop, staged one byte ahead of the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdata_reg <= 8'h00;
        end
        else if (take)
        begin
            wdata_reg <= npic_pkg::ctx_byte(core_ctx, 3'h0);
        end
        else if (state_reg == npic_pkg::ST_PUSH)
        begin
            wdata_reg <= npic_pkg::ctx_byte(ctx_reg, cnt_reg + 3'h1);
        end
    end

    // popped in reverse: cc first, low pc byte last
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rest_reg <= '0;
        end
        else if (state_reg == npic_pkg::ST_POP)
        begin
            case (cnt_reg)
                3'h0: rest_reg.cc <= stack_rdata;
                3'h1: rest_reg.a <= stack_rdata;
                3'h2: rest_reg.x <= stack_rdata;
                3'h3: rest_reg.pc[15:8] <= stack_rdata;
                default: rest_reg.pc[7:0] <= stack_rdata;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_prio_reg <= npic_pkg::PRIO_L3;
        end
        else if (state_reg == npic_pkg::ST_VEC)
        begin
            cur_prio_reg <= ent_prio_reg;
        end
        else if (state_reg == npic_pkg::ST_POP && cnt_reg == 3'h0)
        begin
            cur_prio_reg <= {stack_rdata[npic_pkg::CC_BIT_HIGH],
                stack_rdata[npic_pkg::CC_BIT_LOW]};
        end
        else if (state_reg == npic_pkg::ST_IDLE && cc_sw_wr && !take)
        begin
            cur_prio_reg <= cc_sw_prio;
        end
    end

    assign core_hold = (state_reg != npic_pkg::ST_IDLE);
    assign stack_wr = (state_reg == npic_pkg::ST_PUSH);
    assign stack_wdata = wdata_reg;
    assign stack_rd = (state_reg == npic_pkg::ST_POP);
    assign pc_load = (state_reg == npic_pkg::ST_VEC);
    assign program_counter = ent_vec_reg;
    assign serviced_idx = ent_mask_reg ? ent_idx_reg : 4'h0;
    assign restore_valid = (state_reg == npic_pkg::ST_RESTORE);
    assign restore_ctx = rest_reg;
endmodule
`default_nettype wire

/* File: bench/npic_core_model.sv */
// behavioural core stack that keeps pushed context and hands it back on pops
`timescale 1ns/1ps
`default_nettype none
module npic_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stack_wr,
    input wire logic [7:0] stack_wdata,
    input wire logic stack_rd,
    output logic [7:0] stack_rdata
);
    logic [7:0] mem_reg [0:127];
    logic [6:0] sp_reg;
    logic [7:0] last_reg;
    // idle lines show the inverse of the last popped byte
    assign stack_rdata = stack_rd ? mem_reg[sp_reg + 7'h1] : ~last_reg;
    // grows down and wraps silently
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sp_reg <= 7'h7f;
            last_reg <= 8'h00;
        end
        else if (stack_wr)
        begin
            mem_reg[sp_reg] <= stack_wdata;
            sp_reg <= sp_reg - 7'h1;
        end
        else if (stack_rd)
        begin
            last_reg <= stack_rdata;
            sp_reg <= sp_reg + 7'h1;
        end
    end
endmodule
`default_nettype wire

/* File: bench/npic_ctrl_asserts.sv */
// bound checker for the nested interrupt controller
`timescale 1ns/1ps
`default_nettype none
module npic_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_end,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic stack_wr,
    input wire logic stack_rd,
    input wire logic pc_load,
    input wire logic [15:0] program_counter,
    input wire logic [3:0] serviced_idx,
    input wire logic restore_valid,
    input wire npic_pkg::npic_ctx_s restore_ctx,
    input wire logic halt_exit,
    input wire logic prio_bit_high,
    input wire logic prio_bit_low,
    input wire logic [31:0] vector_priority_regs
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic [1:0] vf;
    logic [1:0] cur;
    logic mld;
    // level number of a code is {xnor, low bit}
    assign vf = vector_priority_regs[{serviced_idx, 1'b0} +: 2];
    assign cur = {prio_bit_high, prio_bit_low};
    assign mld = pc_load && program_counter < 16'hfffa;
    a_push_five: assert property (
        $rose(stack_wr) |-> stack_wr [*5] ##1 (!stack_wr && pc_load))
        else $error("push length");
    a_pop_five: assert property (
        $rose(stack_rd) |-> stack_rd [*5] ##1 restore_valid)
        else $error("pop length");
    a_take_end: assert property (
        $rose(stack_wr) |-> $past(instr_end) || $past(halt_mode) || $past(wait_mode))
        else $error("entry mid instruction");
    a_vec_table: assert property (
        pc_load |-> program_counter[15:5] == 11'h7ff && !program_counter[0])
        else $error("vector outside table");
    a_vec_order: assert property (
        mld |-> program_counter == 16'hfffa - {11'h000, serviced_idx, 1'b0})
        else $error("vector address mismatch");
    a_mask_level: assert property (
        mld |=> cur == $past(vf))
        else $error("stored level not loaded");
    a_mask_above: assert property (
        mld |-> {~^vf, vf[0]} > {~^cur, cur[0]})
        else $error("entry not above level");
    a_nmi_level: assert property (
        pc_load && program_counter >= 16'hfffa |=> cur == 2'h3)
        else $error("non-maskable level");
    a_ret_level: assert property (
        restore_valid |-> cur == {restore_ctx.cc[5], restore_ctx.cc[3]})
        else $error("level not restored");
    a_halt_wake: assert property (
        halt_exit |-> halt_mode ##[1:6] pc_load && program_counter inside
        {16'hfffe, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4})
        else $error("bad halt wake");
    c_trap: cover property (pc_load && program_counter == 16'hfffc);
    c_ret: cover property (restore_valid);
    c_halt: cover property (halt_exit);
endmodule
bind npic_ctrl npic_ctrl_asserts u_npic_ctrl_asserts (.clk, .rst_b, .instr_end, .halt_mode,
    .wait_mode, .stack_wr, .stack_rd, .pc_load, .program_counter, .serviced_idx,
    .restore_valid, .restore_ctx, .halt_exit, .prio_bit_high, .prio_bit_low,
    .vector_priority_regs);
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the nested interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst_b = 1'b0, instr_end = 1'b0, trap_exec = 1'b0;
    logic return_from_irq = 1'b0, halt_mode = 1'b0, wait_mode = 1'b0, cc_sw_wr = 1'b0;
    logic top_level_irq = 1'b0, tli_rising = 1'b1, vpr_wr = 1'b0;
    logic [1:0] cc_sw_prio = 2'h0, vpr_wr_idx = 2'h0;
    logic [3:0] ext_pin = 4'hf;
    logic [7:0] ext_irq_sense_reg = 8'h00, vpr_wdata = 8'h00, stack_rdata, stack_wdata;
    logic [13:0] periph_flag = 14'h0000, periph_en = 14'h0000, periph_clear = 14'h0000;
    npic_pkg::npic_ctx_s core_ctx = 40'h0, restore_ctx;
    logic core_hold, stack_wr, stack_rd, pc_load, restore_valid, halt_exit, wait_exit;
    logic prio_bit_high, prio_bit_low;
    logic [15:0] program_counter;
    logic [3:0] serviced_idx;
    logic [31:0] vector_priority_regs;
    int num_errors = 0, compares = 0;
    npic_ctrl u_npic_ctrl (.clk, .rst_b, .instr_end, .trap_exec, .return_from_irq,
        .halt_mode, .wait_mode, .cc_sw_wr, .cc_sw_prio, .core_ctx, .top_level_irq,
        .tli_rising, .ext_pin, .ext_irq_sense_reg, .periph_flag, .periph_en, .periph_clear,
        .vpr_wr, .vpr_wr_idx, .vpr_wdata, .stack_rdata, .core_hold, .stack_wr, .stack_wdata,
        .stack_rd, .pc_load, .program_counter, .serviced_idx, .restore_valid, .restore_ctx,
        .halt_exit, .wait_exit, .prio_bit_high, .prio_bit_low, .vector_priority_regs);
    npic_core_model u_npic_core_model (.clk, .rst_b, .stack_wr, .stack_wdata, .stack_rd,
        .stack_rdata);
    initial forever #2.5 clk = ~clk;
    // context whose cc bits hold the given level
    function automatic npic_pkg::npic_ctx_s mk(input logic [7:0] n, input logic [1:0] p);
        mk = {n, n, ~n, n, 2'h3, p[1], 1'b0, p[0], 3'h5};
    endfunction
    task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input logic t);
        trap_exec <= t;
        instr_end <= 1'b1;
        @(posedge clk);
        trap_exec <= 1'b0;
        instr_end <= 1'b0;
    endtask
    task automatic wait_on(input int s);
        int n;
        n = 0;
        while (n < 20 && (s == 0 ? pc_load : s == 1 ? restore_valid : s == 2 ? halt_exit
            : wait_exit) !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        num_errors += (n == 20);
    endtask
    task automatic enter(input logic [15:0] pc, input logic [3:0] idx, input logic [1:0] lv);
        wait_on(0);
        chk("program_counter", program_counter, pc);
        chk("serviced_idx", serviced_idx, idx);
        @(negedge clk);
        chk("prio", {prio_bit_high, prio_bit_low}, lv);
        chk("core_hold", core_hold, 1'b0);
        @(posedge clk);
    endtask
    task automatic ret(input npic_pkg::npic_ctx_s c);
        return_from_irq <= 1'b1;
        @(posedge clk);
        return_from_irq <= 1'b0;
        wait_on(1);
        chk("restore_ctx", restore_ctx, c);
        chk("prio", {prio_bit_high, prio_bit_low}, {c.cc[5], c.cc[3]});
        @(posedge clk);
    endtask
    task automatic wvpr(input logic [1:0] i, input logic [7:0] d);
        vpr_wr <= 1'b1;
        vpr_wr_idx <= i;
        vpr_wdata <= d;
        @(posedge clk);
        vpr_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic no_take(input logic [15:0] pc);
        repeat (10) @(posedge clk);
        chk("program_counter", program_counter, pc);
    endtask
    task automatic drop(input logic [13:0] m);
        periph_flag <= periph_flag & ~m;
        periph_clear <= m;
        @(posedge clk);
        periph_clear <= 14'h0000;
    endtask
    task automatic leave(input int s);
        wait_on(s);
        chk("low_power_exit", s == 2 ? halt_exit : wait_exit, 1'b1);
        @(posedge clk);
        halt_mode <= 1'b0;
        wait_mode <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        chk("prio", {prio_bit_high, prio_bit_low}, 2'h3);
        chk("vector_priority_regs", vector_priority_regs, 32'hffffffff);
        rst_b <= 1'b1;
        enter(16'hfffe, 4'h0, 2'h3);
        wvpr(2'h1, 8'hcf);
        wvpr(2'h1, 8'h64);
        chk("vector_priority_regs", vector_priority_regs[15:8], 8'h44);
        wvpr(2'h3, 8'h00);
        wvpr(2'h0, 8'h13);
        chk("vector_priority_regs", vector_priority_regs, 32'hf0ff4413);
        core_ctx <= mk(8'h11, 2'h2);
        periph_en <= 14'h3fff;
        periph_flag <= 14'h0020;
        step(1'b0);
        no_take(16'hfffe);
        cc_sw_wr <= 1'b1;
        cc_sw_prio <= 2'h2;
        @(posedge clk);
        cc_sw_wr <= 1'b0;
        @(negedge clk);
        chk("prio", {prio_bit_high, prio_bit_low}, 2'h2);
        @(posedge clk);
        step(1'b0);
        enter(16'hfff0, 4'h5, 2'h1);
        core_ctx <= mk(8'h22, 2'h1);
        periph_flag <= 14'h20f0;
        @(posedge clk);
        step(1'b0);
        enter(16'hfff2, 4'h4, 2'h0);
        drop(14'h0010);
        step(1'b0);
        no_take(16'hfff2);
        ret(mk(8'h22, 2'h1));
        core_ctx <= mk(8'h33, 2'h1);
        step(1'b0);
        enter(16'hffee, 4'h6, 2'h0);
        ret(mk(8'h33, 2'h1));
        drop(14'h3fff);
        ret(mk(8'h11, 2'h2));
        core_ctx <= mk(8'h44, 2'h2);
        step(1'b1);
        enter(16'hfffc, 4'h0, 2'h3);
        core_ctx <= mk(8'h55, 2'h3);
        top_level_irq <= 1'b1;
        repeat (3) @(posedge clk);
        step(1'b0);
        enter(16'hfffa, 4'h0, 2'h3);
        // the top irq handler issues no trap
        ret(mk(8'h55, 2'h3));
        ret(mk(8'h44, 2'h2));
        ext_irq_sense_reg <= 8'h21;
        core_ctx <= mk(8'h66, 2'h2);
        periph_flag <= 14'h0010;
        halt_mode <= 1'b1;
        no_take(16'hfffa);
        ext_pin <= 4'he;
        leave(2);
        enter(16'hfff6, 4'h2, 2'h1);
        ret(mk(8'h66, 2'h2));
        wait_mode <= 1'b1;
        leave(3);
        enter(16'hfff2, 4'h4, 2'h0);
        drop(14'h0010);
        ret(mk(8'h66, 2'h2));
        step(1'b0);
        no_take(16'hfff2);
        end_of_test();
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
